// ==== io_process_map.svh ====
// register offsets, codes and timing constants for the process register bank
`ifndef IO_PROCESS_MAP_SVH
`define IO_PROCESS_MAP_SVH
`define ADDR_SHORT_LOC 16'h1F3E
`define ADDR_PROC_IN 16'h1F40
`define ADDR_PROC_OUT 16'h2328
`define SHORT_NONE 16'h0000
`define SHORT_GRP_LO 16'h0001
`define SHORT_GRP_HI 16'h0002
`define DIAG_SHORT_BIT 0
`define RESTORE_POS 4'hF
`define CLK_MHZ 250
`define CONNECT_READY_MS 350
`define CYCLIC_READY_MS 500
`define CONNECT_READY_CYC (`CONNECT_READY_MS * 1000 * `CLK_MHZ)
`define CYCLIC_READY_CYC (`CYCLIC_READY_MS * 1000 * `CLK_MHZ)
`define UPPER_ZERO 8'h00
`define REG_CLEAR 16'h0000
`define GRP_LO_MASK 8'h0F
`define GRP_HI_MASK 8'hF0
`endif

// ==== io_process_pkg.sv ====
// types for the process register bank
`default_nettype none
package io_process_pkg;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [2:0] {
    ST_BOOT = 3'h1,
    ST_CONNECT = 3'h2,
    ST_CYCLIC = 3'h4
  } startup_t;
endpackage
`default_nettype wire

// ==== ready_timer.sv ====
// one up-counting timer that raises done after a programmable cycle count
`default_nettype none
module ready_timer #(
  parameter int unsigned COUNT = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // status
  output logic done
);
  logic [31:0] count_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_ff <= 32'h00000000;
    end else if (count_ff < COUNT - 32'h00000001) begin
      count_ff <= count_ff + 32'h00000001;
    end
  end
  assign done = (count_ff >= COUNT - 32'h00000001) && !reset;
endmodule // ready_timer
`default_nettype wire

// ==== io_process_regs.sv ====
// register bank holding process input, output and short circuit words
// Notes on behaviour
// - short location word: 0 none, 1 low, 2 high
// - input word bit n carries input n+1
// - output word bit n drives output n+1
// - words big-endian, mapped without byte swap
// - one-byte process data sits in low byte
// - upper byte reads zero, writes ignored
// - connection accepted within 350 ms of power
// - cyclic connection established under 500 ms
// - rotary position 0F restores factory defaults
// - diagnostic status bit 0 flags output short
`include "io_process_map.svh"
`default_nettype none
module io_process_regs #(
  parameter int unsigned CONNECT_CYC = `CONNECT_READY_CYC,
  parameter int unsigned CYCLIC_CYC = `CYCLIC_READY_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  // field channels
  input wire logic [7:0] field_input_channel,
  input wire logic [7:0] output_short,
  output logic [7:0] field_output_channel,
  // diagnostics
  output logic [15:0] diag_status,
  // configuration switch
  input wire logic [3:0] rotary_switch,
  output logic restore_defaults,
  // startup
  output logic connect_ready,
  output logic cyclic_ready
);
  io_process_pkg::reg_word_t rdata_ff;
  io_process_pkg::reg_word_t short_loc_ff;
  io_process_pkg::startup_t state_ff;
  io_process_pkg::startup_t nxt_state;
  logic ack_ff;
  logic err_ff;
  logic [7:0] in_ff;
  logic [7:0] out_ff;
  logic restore_ff;
  logic conn_done;
  logic cyc_done;
  logic hit_loc;
  logic hit_in;
  logic hit_out;
  io_process_pkg::reg_word_t nxt_rdata;
  io_process_pkg::reg_word_t nxt_short_loc;
  io_process_pkg::reg_word_t nxt_diag;
  io_process_pkg::reg_word_t diag_ff;
  logic rd_take;
  logic wr_take;
  logic bad_rd;
  logic bad_wr;

  assign hit_loc = reg_addr == `ADDR_SHORT_LOC;
  assign hit_in = reg_addr == `ADDR_PROC_IN;
  assign hit_out = reg_addr == `ADDR_PROC_OUT;

  // accepted accesses and refused targets
  assign rd_take = reg_rd && connect_ready;
  assign wr_take = reg_wr && connect_ready;
  assign bad_rd = rd_take && !(hit_loc || hit_in || hit_out);
  assign bad_wr = wr_take && !hit_out;

  // startup deadlines
  ready_timer #(.COUNT(CONNECT_CYC)) u_conn_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .done(conn_done)
  );
  ready_timer #(.COUNT(CYCLIC_CYC)) u_cyc_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .done(cyc_done)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      io_process_pkg::ST_BOOT: begin
        if (conn_done) nxt_state = io_process_pkg::ST_CONNECT;
      end
      io_process_pkg::ST_CONNECT: begin
        if (cyc_done) nxt_state = io_process_pkg::ST_CYCLIC;
      end
      io_process_pkg::ST_CYCLIC: nxt_state = io_process_pkg::ST_CYCLIC;
      default: nxt_state = io_process_pkg::ST_BOOT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= io_process_pkg::ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign connect_ready = state_ff != io_process_pkg::ST_BOOT;
  assign cyclic_ready = state_ff == io_process_pkg::ST_CYCLIC;

  // input sampling
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      in_ff <= `UPPER_ZERO;
    end else begin
      in_ff <= field_input_channel;
    end
  end

  // output word, writable only when connected
  always_ff @(posedge sys_clk) begin
    if (reset || restore_ff) begin
      out_ff <= `UPPER_ZERO;
    end else if (wr_take && hit_out) begin
      out_ff <= reg_wdata[7:0];
    end
  end
  assign field_output_channel = out_ff;

  // short circuit location, live and self-clearing
  always_comb begin
    nxt_short_loc = `SHORT_NONE;
    if ((output_short & `GRP_LO_MASK) != `UPPER_ZERO) begin
      nxt_short_loc = `SHORT_GRP_LO;
    end else if ((output_short & `GRP_HI_MASK) != `UPPER_ZERO) begin
      nxt_short_loc = `SHORT_GRP_HI;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      short_loc_ff <= `SHORT_NONE;
    end else begin
      short_loc_ff <= nxt_short_loc;
    end
  end

  // diagnostic status word, only the output short flag lives here
  always_comb begin
    nxt_diag = `REG_CLEAR;
    nxt_diag[`DIAG_SHORT_BIT] = nxt_short_loc != `SHORT_NONE;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      diag_ff <= `REG_CLEAR;
    end else begin
      diag_ff <= nxt_diag;
    end
  end
  assign diag_status = diag_ff;

  // rotary restore request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      restore_ff <= 1'b0;
    end else begin
      restore_ff <= rotary_switch == `RESTORE_POS;
    end
  end
  assign restore_defaults = restore_ff;

  // read data multiplexer, unmapped reads return zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_take) begin
      if (hit_loc) begin
        nxt_rdata = short_loc_ff;
      end else if (hit_in) begin
        nxt_rdata = {`UPPER_ZERO, in_ff};
      end else if (hit_out) begin
        nxt_rdata = {`UPPER_ZERO, out_ff};
      end else begin
        nxt_rdata = `REG_CLEAR;
      end
    end
  end

  // read data register, holds until the next read
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdata_ff <= `REG_CLEAR;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // answer strobe, one cycle after every accepted access
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= rd_take || wr_take;
    end
  end

  // error strobe for refused reads and writes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= bad_rd || bad_wr;
    end
  end
  assign reg_rdata = rdata_ff;
  assign reg_ack = ack_ff;
  assign reg_err = err_ff;
endmodule // io_process_regs
`default_nettype wire

// ==== io_process_checker.sv ====
// checker for the process register bank
`default_nettype none
module io_process_checker #(
  parameter int CONNECT_CYC = 20,
  parameter int CYCLIC_CYC = 40
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register access
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err,
  // field side and diagnostics
  input wire logic [7:0] output_short,
  input wire logic [7:0] field_output_channel,
  input wire logic [15:0] diag_status,
  // switch and startup
  input wire logic [3:0] rotary_switch,
  input wire logic restore_defaults,
  input wire logic connect_ready,
  input wire logic cyclic_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] age_ff;
  wire logic take = (reg_rd | reg_wr) & connect_ready;
  wire logic wr_out = take & reg_wr & (reg_addr == 16'h2328);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      age_ff <= 8'h00;
    end else if (age_ff != 8'hFF) begin
      age_ff <= age_ff + 8'h01;
    end
  end
  a_ack_due: assert property (take |=> reg_ack)
    else $error("ack missing");
  a_out_byte: assert property (wr_out && !restore_defaults
    |=> field_output_channel == $past(reg_wdata[7:0]))
    else $error("output byte wrong");
  a_high_zero: assert property (
    reg_ack |-> reg_rdata[15:8] == 8'h00)
    else $error("upper byte set");
  a_ro_err: assert property (
    take && reg_wr |=> reg_err != $past(wr_out))
    else $error("write error flag wrong");
  a_diag_flag: assert property (1
    |=> diag_status == {15'h0000, |$past(output_short)})
    else $error("diag status wrong");
  a_restore_level: assert property (1
    |=> restore_defaults == ($past(rotary_switch) == 4'hF))
    else $error("restore wrong");
  a_connect_due: assert property (
    age_ff > CONNECT_CYC + 2 |-> connect_ready)
    else $error("connect late");
  a_cyclic_due: assert property (
    age_ff > CYCLIC_CYC + 2 |-> cyclic_ready)
    else $error("cyclic late");
  c_write: cover property (wr_out);
  c_err: cover property (reg_err);
  c_short: cover property (diag_status[0]);
  c_restore: cover property (restore_defaults);
endmodule // io_process_checker
`default_nettype wire

// ==== io_process_client.sv ====
// network client model issuing register reads and writes
`default_nettype none
module io_process_client (
  // clock and answer
  input wire logic sys_clk,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [15:0] reg_rdata,
  // request
  output var logic reg_rd,
  output var logic reg_wr,
  output var logic [15:0] reg_addr,
  output var logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle request lines until the first transfer
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
  end
  // one-cycle request, answer taken a cycle later
  task automatic xfer(input logic w, input logic [15:0] a, d,
    output logic [15:0] q, output logic [1:0] e);
    @(negedge sys_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    {reg_wr, reg_rd} = 2'b00;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    e = {reg_ack, reg_err};
  endtask
endmodule // io_process_client
`default_nettype wire

// ==== io_process_regs_bench.sv ====
// self-checking bench for the process register bank
`include "io_process_map.svh"
`default_nettype none
module io_process_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, reg_rd, reg_wr, reg_ack, reg_err;
  logic restore_defaults, connect_ready, cyclic_ready;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, diag_status, q, wd;
  logic [7:0] field_input_channel, output_short, field_output_channel;
  logic [7:0] shorts [4] = '{8'h08, 8'h81, 8'h40, 8'h00};
  logic [15:0] bad_adr [3] = '{16'h1F40, 16'h1F3E, 16'h0000};
  logic [3:0] rotary_switch;
  logic [1:0] e;
  int bad_count, comparisons;
  io_process_regs #(
    .CONNECT_CYC(20),
    .CYCLIC_CYC(40)
  ) dut_u (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_ack(reg_ack),
    .reg_err(reg_err),
    .field_input_channel(field_input_channel),
    .output_short(output_short),
    .field_output_channel(field_output_channel),
    .diag_status(diag_status),
    .rotary_switch(rotary_switch),
    .restore_defaults(restore_defaults),
    .connect_ready(connect_ready),
    .cyclic_ready(cyclic_ready)
  );
  io_process_client client_u (
    .sys_clk(sys_clk),
    .reg_ack(reg_ack),
    .reg_err(reg_err),
    .reg_rdata(reg_rdata),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata)
  );
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d of %0d checks", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] loc(logic [7:0] s);
    return |s[3:0] ? `SHORT_GRP_LO : |s[7:4] ? `SHORT_GRP_HI : `SHORT_NONE;
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    {reset, rotary_switch, output_short, field_input_channel} = 21'h100000;
    void'($urandom(32'hDD39));
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    client_u.xfer(1'b0, 16'h1F40, 16'h0000, q, e);
    chk({e, connect_ready}, 3'h0);
    repeat (45) @(negedge sys_clk);
    chk({connect_ready, cyclic_ready}, 2'b11);
    for (int i = 0; i < 8; i++) begin
      wd = i == 0 ? 16'hFF00 : i == 1 ? 16'h00FF : 16'($urandom);
      field_input_channel = wd[15:8];
      client_u.xfer(1'b1, 16'h2328, wd, q, e);
      chk({e, 6'h00, field_output_channel}, {8'h80, wd[7:0]});
      client_u.xfer(1'b0, 16'h2328, ~wd, q, e);
      chk(q, {8'h00, wd[7:0]});
      client_u.xfer(1'b0, 16'h1F40, wd, q, e);
      chk(q, {8'h00, wd[15:8]});
    end
    foreach (bad_adr[k]) begin
      client_u.xfer(k < 2, bad_adr[k], 16'hFFFF, q, e);
      chk(e, 2'b11);
    end
    foreach (shorts[k]) begin
      output_short = shorts[k];
      client_u.xfer(1'b0, 16'h1F3E, 16'h0000, q, e);
      chk(q, loc(shorts[k]));
      chk(diag_status, {15'h0000, |shorts[k]});
    end
    rotary_switch = 4'hF;
    repeat (3) @(negedge sys_clk);
    chk({restore_defaults, field_output_channel}, 9'h100);
    conclude();
  end
endmodule // io_process_regs_bench
bind io_process_regs io_process_checker #(
  .CONNECT_CYC(CONNECT_CYC),
  .CYCLIC_CYC(CYCLIC_CYC)
) chk_u (
  .sys_clk(sys_clk),
  .reset(reset),
  .reg_rd(reg_rd),
  .reg_wr(reg_wr),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_ack(reg_ack),
  .reg_err(reg_err),
  .output_short(output_short),
  .field_output_channel(field_output_channel),
  .diag_status(diag_status),
  .rotary_switch(rotary_switch),
  .restore_defaults(restore_defaults),
  .connect_ready(connect_ready),
  .cyclic_ready(cyclic_ready)
);
`default_nettype wire
